// >>> rtl/port_lookup_ptp_config.sv
// Per-port ingress lookup policy, spanning-tree state and PTP delay configuration.
// Assumes an AHB-Lite master with single word transfers and a lookup engine that
// presents one frame per FRAME_VALID pulse with its VLAN membership already resolved.
//
// Contract
// - Null lookup bit set: tagged VID 0 looks up VID 0, else default VID
// - Ingress filtering bit drops frames whose VLAN excludes this port
// - Discard bit drops frames whose VID differs from the default VID
// - Bit 4 enables MAC based 802.1X authentication in the lookup engine
// - Self filtering drops frames whose source MAC equals the switch MAC
// - Self filtering needs both the port bit and the global enable
// - Three-bit read/write instance pointer, reset zero, selects one of eight; the code stores and reads back all eight bits, low three select
// - Eight state entries; state register accesses only the pointed entry
// - State bit 2, reset one, permits transmission
// - State bit 1, reset one, permits reception
// - State bit 0, reset zero, stops source address learning
// - Sixteen-bit receive wire delay in ns, reset 415
// - Sixteen-bit transmit wire delay in ns, reset 45
// - Asymmetry is sign-magnitude: bit 15 negative, 15-bit magnitude, reset zero
// - Add signed asymmetry to ingress Sync and Pdelay_Resp correction
// - Subtract signed asymmetry from egress Delay_Req and Pdelay_Req correction
module port_lookup_ptp_config
  import port_cfg_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [15:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire logic FRAME_VALID,
  input wire logic FRAME_TAGGED,
  input wire logic [11:0] FRAME_VID,
  input wire logic [11:0] DEFAULT_VID,
  input wire logic VLAN_MEMBER,
  input wire logic [47:0] SOURCE_MAC,
  input wire logic [47:0] SWITCH_MAC,
  input wire logic GLOBAL_SELF_FILTER,
  output logic DECISION_VALID,
  output logic FRAME_DROP,
  output logic [11:0] LOOKUP_VID,
  output logic MAC_AUTH_EN,
  output logic [7:0] TREE_TX_EN,
  output logic [7:0] TREE_RX_EN,
  output logic [7:0] TREE_LEARN_DIS,
  output logic [15:0] RX_WIRE_DELAY_NS,
  output logic [15:0] TX_WIRE_DELAY_NS,
  input wire logic PTP_VALID,
  input wire logic PTP_INGRESS,
  input wire logic [3:0] PTP_MSG_TYPE,
  input wire logic [63:0] PTP_CORR_IN,
  output logic PTP_CORR_VALID,
  output logic PTP_CORR_OUT_ADJUSTED,
  output logic [63:0] PTP_CORR_OUT
);

  // ****************************************
  // Bus slave
  // ****************************************
  logic addr_phase;
  logic wr_pend;
  logic [15:0] wr_addr;
  logic [7:0] lookup_ctrl;
  logic [7:0] tree_ptr;
  logic [15:0] rx_wire_delay_ns;
  logic [15:0] tx_wire_delay_ns;
  logic [15:0] asymmetry;
  logic [7:0] selected_state;
  logic [31:0] next_rdata;

  // Zero wait states: every transfer completes in its first data phase
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign addr_phase = HSEL && HTRANS[1] && HREADY;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      wr_pend <= 1'b0;
      wr_addr <= 16'h0000;
    end else begin
      wr_pend <= addr_phase && HWRITE;
      wr_addr <= HADDR;
    end
  end

  // Entry picked by the pointer at the address phase
  assign selected_state = {5'h00, TREE_TX_EN[tree_ptr[2:0]], TREE_RX_EN[tree_ptr[2:0]],
    TREE_LEARN_DIS[tree_ptr[2:0]]};

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (HADDR)
      ADDR_LOOKUP_CTRL: next_rdata = {24'h000000, lookup_ctrl & CTRL_RW_MASK};
      ADDR_TREE_PTR: next_rdata = {24'h000000, tree_ptr};
      ADDR_TREE_STATE: next_rdata = {24'h000000, selected_state};
      ADDR_RX_DELAY: next_rdata = {16'h0000, rx_wire_delay_ns};
      ADDR_TX_DELAY: next_rdata = {16'h0000, tx_wire_delay_ns};
      ADDR_ASYM: next_rdata = {16'h0000, asymmetry};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is captured at the address phase so it is a flop output
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      HRDATA <= 32'h0000_0000;
    end else if (addr_phase && !HWRITE) begin
      HRDATA <= next_rdata;
    end
  end

  // ****************************************
  // Lookup control register
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      lookup_ctrl <= CTRL_RESET;
    end else if (wr_pend && wr_addr == ADDR_LOOKUP_CTRL) begin
      lookup_ctrl <= HWDATA[7:0] & CTRL_RW_MASK;
    end
  end

  assign MAC_AUTH_EN = lookup_ctrl[CTRL_MAC_AUTH];

  // ****************************************
  // Spanning-tree pointer and state
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      tree_ptr <= PTR_RESET;
    end else if (wr_pend && wr_addr == ADDR_TREE_PTR) begin
      tree_ptr <= HWDATA[7:0];
    end
  end

  // Upper state bits are not stored, so they read zero
  genvar gi;
  generate
    for (gi = 0; gi < TREE_INSTANCES; gi++) begin : g_tree
      always_ff @(posedge CLK) begin
        if (!NRST) begin
          TREE_TX_EN[gi] <= STATE_TX_RESET;
          TREE_RX_EN[gi] <= STATE_RX_RESET;
          TREE_LEARN_DIS[gi] <= STATE_LEARN_RESET;
        end else if (wr_pend && wr_addr == ADDR_TREE_STATE && tree_ptr[2:0] == 3'(gi)) begin
          TREE_TX_EN[gi] <= HWDATA[STATE_TX_EN];
          TREE_RX_EN[gi] <= HWDATA[STATE_RX_EN];
          TREE_LEARN_DIS[gi] <= HWDATA[STATE_LEARN_DIS];
        end
      end
    end
  endgenerate

  // ****************************************
  // PTP delay registers
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rx_wire_delay_ns <= RX_DELAY_RESET_NS;
    end else if (wr_pend && wr_addr == ADDR_RX_DELAY) begin
      rx_wire_delay_ns <= HWDATA[15:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      tx_wire_delay_ns <= TX_DELAY_RESET_NS;
    end else if (wr_pend && wr_addr == ADDR_TX_DELAY) begin
      tx_wire_delay_ns <= HWDATA[15:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      asymmetry <= ASYM_RESET;
    end else if (wr_pend && wr_addr == ADDR_ASYM) begin
      asymmetry <= HWDATA[15:0];
    end
  end

  assign RX_WIRE_DELAY_NS = rx_wire_delay_ns;
  assign TX_WIRE_DELAY_NS = tx_wire_delay_ns;

  // ****************************************
  // Ingress frame decision
  // ****************************************
  logic use_default_vid;
  logic [11:0] next_lookup_vid;
  logic self_filter_on;
  logic next_drop;

  // Untagged frames always take the default VID
  assign use_default_vid = !FRAME_TAGGED ||
    (FRAME_VID == 12'h000 && !lookup_ctrl[CTRL_NULL_VID]);
  assign next_lookup_vid = use_default_vid ? DEFAULT_VID : FRAME_VID;
  assign self_filter_on = lookup_ctrl[CTRL_SELF_FILTER] && GLOBAL_SELF_FILTER;

  always_comb begin
    next_drop = 1'b0;
    if (lookup_ctrl[CTRL_VLAN_FILTER] && !VLAN_MEMBER) begin
      next_drop = 1'b1;
    end
    if (lookup_ctrl[CTRL_PVID_DISCARD] && next_lookup_vid != DEFAULT_VID) begin
      next_drop = 1'b1;
    end
    if (self_filter_on && SOURCE_MAC == SWITCH_MAC) begin
      next_drop = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      DECISION_VALID <= 1'b0;
      FRAME_DROP <= 1'b0;
      LOOKUP_VID <= 12'h000;
    end else begin
      DECISION_VALID <= FRAME_VALID;
      if (FRAME_VALID) begin
        FRAME_DROP <= next_drop;
        LOOKUP_VID <= next_lookup_vid;
      end
    end
  end

  // ****************************************
  // PTP correction field adjustment
  // ****************************************
  logic [63:0] next_corr;
  logic next_adjusted;

  asym_correction u_asym (
    .asym(asymmetry),
    .ingress(PTP_INGRESS),
    .msg_type(PTP_MSG_TYPE),
    .corr_in(PTP_CORR_IN),
    .corr_out(next_corr),
    .adjusted(next_adjusted)
  );

  // One cycle of latency; the adder chain is kept out of the message path
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      PTP_CORR_VALID <= 1'b0;
      PTP_CORR_OUT_ADJUSTED <= 1'b0;
      PTP_CORR_OUT <= 64'h0;
    end else begin
      PTP_CORR_VALID <= PTP_VALID;
      if (PTP_VALID) begin
        PTP_CORR_OUT <= next_corr;
        PTP_CORR_OUT_ADJUSTED <= next_adjusted;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [63:0] chk_asym_value;
  assign chk_asym_value = asymmetry[15] ? (64'h0 - {33'h0, asymmetry[14:0], 16'h0000}) :
    {33'h0, asymmetry[14:0], 16'h0000};

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  chk_null_vid_on: assert property (
    FRAME_VALID && FRAME_TAGGED && FRAME_VID == 12'h000 && lookup_ctrl[7]
    |=> DECISION_VALID && LOOKUP_VID == 12'h000)
    else $error("VID 0 lookup not used with null lookup enabled");

  chk_null_vid_off: assert property (
    FRAME_VALID && FRAME_TAGGED && FRAME_VID == 12'h000 && !lookup_ctrl[7]
    |=> LOOKUP_VID == $past(DEFAULT_VID))
    else $error("Default VID not used for VID 0 frame");

  chk_member_filter: assert property (
    FRAME_VALID && lookup_ctrl[6] && !VLAN_MEMBER |=> FRAME_DROP)
    else $error("Non-member frame not dropped");

  chk_no_filtering: assert property (
    FRAME_VALID && !lookup_ctrl[6] && !lookup_ctrl[5] && !(lookup_ctrl[3] && GLOBAL_SELF_FILTER)
    |=> !FRAME_DROP)
    else $error("Frame dropped with all filters off");

  chk_pvid_discard: assert property (
    FRAME_VALID && lookup_ctrl[5] && FRAME_TAGGED && FRAME_VID != 12'h000 &&
    FRAME_VID != DEFAULT_VID |=> FRAME_DROP)
    else $error("Non-default VID frame not dropped");

  chk_self_drop: assert property (
    FRAME_VALID && lookup_ctrl[3] && GLOBAL_SELF_FILTER && SOURCE_MAC == SWITCH_MAC
    |=> FRAME_DROP)
    else $error("Own source address not dropped");

  chk_auth_enable: assert property (
    wr_pend && wr_addr == ADDR_LOOKUP_CTRL |=> MAC_AUTH_EN == $past(HWDATA[4]))
    else $error("Authentication enable does not follow write");

  chk_ptr_write: assert property (
    wr_pend && wr_addr == ADDR_TREE_PTR |=> tree_ptr == $past(HWDATA[7:0]))
    else $error("Pointer write lost");

  chk_state_select: assert property (
    wr_pend && wr_addr == ADDR_TREE_STATE |=>
    TREE_TX_EN == (($past(TREE_TX_EN) & ~(8'h01 << $past(tree_ptr[2:0]))) |
    ({7'h00, $past(HWDATA[2])} << $past(tree_ptr[2:0]))))
    else $error("State write touched the wrong instance");

  chk_state_rx_write: assert property (
    wr_pend && wr_addr == ADDR_TREE_STATE |=>
    TREE_RX_EN == (($past(TREE_RX_EN) & ~(8'h01 << $past(tree_ptr[2:0]))) |
    ({7'h00, $past(HWDATA[STATE_RX_EN])} << $past(tree_ptr[2:0]))))
    else $error("Receive enable written to the wrong instance");

  chk_state_learn_write: assert property (
    wr_pend && wr_addr == ADDR_TREE_STATE |=>
    TREE_LEARN_DIS == (($past(TREE_LEARN_DIS) & ~(8'h01 << $past(tree_ptr[2:0]))) |
    ({7'h00, $past(HWDATA[STATE_LEARN_DIS])} << $past(tree_ptr[2:0]))))
    else $error("Learning disable written to the wrong instance");

  chk_rx_delay_write: assert property (
    wr_pend && wr_addr == ADDR_RX_DELAY |=> RX_WIRE_DELAY_NS == $past(HWDATA[15:0]))
    else $error("Receive wire delay write lost");

  chk_tx_delay_write: assert property (
    wr_pend && wr_addr == ADDR_TX_DELAY |=> TX_WIRE_DELAY_NS == $past(HWDATA[15:0]))
    else $error("Transmit wire delay write lost");

  chk_ctrl_reserved: assert property (
    $past(addr_phase && !HWRITE && HADDR == ADDR_LOOKUP_CTRL) |->
    HRDATA[2] == 1'b0 && HRDATA[0] == 1'b0 && HRDATA[31:8] == 24'h000000)
    else $error("Read-only reserved bits not zero");

  chk_asym_add: assert property (
    PTP_VALID && PTP_INGRESS && PTP_MSG_TYPE == MSG_PDELAY_RESP
    |=> PTP_CORR_OUT == $past(PTP_CORR_IN) + $past(chk_asym_value))
    else $error("Ingress correction not increased by asymmetry");

  chk_asym_sub: assert property (
    PTP_VALID && !PTP_INGRESS && PTP_MSG_TYPE == MSG_DELAY_REQ
    |=> PTP_CORR_OUT == $past(PTP_CORR_IN) - $past(chk_asym_value))
    else $error("Egress correction not reduced by asymmetry");

  chk_reset_values: assert property (disable iff (1'b0)
    !NRST |=> RX_WIRE_DELAY_NS == 16'h019f && TX_WIRE_DELAY_NS == 16'h002d &&
    TREE_TX_EN == 8'hff && TREE_RX_EN == 8'hff && TREE_LEARN_DIS == 8'h00)
    else $error("Reset values wrong");

  cov_frame_drop: cover property (FRAME_VALID ##1 FRAME_DROP);
  cov_state_write: cover property (wr_pend && wr_addr == ADDR_TREE_STATE && tree_ptr[2:0] == 3'h7);
  cov_negative_asym: cover property (PTP_VALID && asymmetry[15] ##1 PTP_CORR_OUT_ADJUSTED);
  cov_null_vid: cover property (FRAME_VALID && FRAME_TAGGED && FRAME_VID == 12'h000);

endmodule

// >>> rtl/port_cfg_pkg.sv
// Constants for the per-port lookup, spanning-tree and PTP configuration bank.
// Assumes a 32-bit AHB-Lite bus with one word per register index.
package port_cfg_pkg;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam logic [15:0] IDX_LOOKUP_CTRL = 16'h0b00;
  localparam logic [15:0] IDX_TREE_PTR = 16'h0b01;
  localparam logic [15:0] IDX_TREE_STATE = 16'h0b04;
  localparam logic [15:0] IDX_RX_DELAY = 16'h0c00;
  localparam logic [15:0] IDX_TX_DELAY = 16'h0c02;
  localparam logic [15:0] IDX_ASYM = 16'h0c04;
  // Byte address is four times the index
  localparam logic [15:0] ADDR_LOOKUP_CTRL = {IDX_LOOKUP_CTRL[13:0], 2'b00};
  localparam logic [15:0] ADDR_TREE_PTR = {IDX_TREE_PTR[13:0], 2'b00};
  localparam logic [15:0] ADDR_TREE_STATE = {IDX_TREE_STATE[13:0], 2'b00};
  localparam logic [15:0] ADDR_RX_DELAY = {IDX_RX_DELAY[13:0], 2'b00};
  localparam logic [15:0] ADDR_TX_DELAY = {IDX_TX_DELAY[13:0], 2'b00};
  localparam logic [15:0] ADDR_ASYM = {IDX_ASYM[13:0], 2'b00};

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_NULL_VID = 7;
  localparam int CTRL_VLAN_FILTER = 6;
  localparam int CTRL_PVID_DISCARD = 5;
  localparam int CTRL_MAC_AUTH = 4;
  localparam int CTRL_SELF_FILTER = 3;
  localparam int STATE_TX_EN = 2;
  localparam int STATE_RX_EN = 1;
  localparam int STATE_LEARN_DIS = 0;
  localparam int ASYM_SIGN = 15;
  localparam int CORR_FRAC_BITS = 16;
  localparam int TREE_INSTANCES = 8;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RW_MASK = 8'hfa;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic STATE_TX_RESET = 1'b1;
  localparam logic STATE_RX_RESET = 1'b1;
  localparam logic STATE_LEARN_RESET = 1'b0;
  localparam logic [15:0] RX_DELAY_RESET_NS = 16'h019f;
  localparam logic [15:0] TX_DELAY_RESET_NS = 16'h002d;
  localparam logic [15:0] ASYM_RESET = 16'h0000;

  // ****************************************
  // PTP message types
  // ****************************************
  localparam logic [3:0] MSG_SYNC = 4'h0;
  localparam logic [3:0] MSG_DELAY_REQ = 4'h1;
  localparam logic [3:0] MSG_PDELAY_REQ = 4'h2;
  localparam logic [3:0] MSG_PDELAY_RESP = 4'h3;

endpackage

// >>> rtl/asym_correction.sv
// Combinational asymmetry adjustment of a PTP correction field.
// Assumes the caller registers the result; correction field is ns scaled by 2^16.
module asym_correction
  import port_cfg_pkg::*;
(
  input wire logic [15:0] asym,
  input wire logic ingress,
  input wire logic [3:0] msg_type,
  input wire logic [63:0] corr_in,
  output logic [63:0] corr_out,
  output logic adjusted
);

  logic [63:0] magnitude;
  logic [63:0] signed_value;
  logic do_add;
  logic do_sub;

  // ****************************************
  // Sign-magnitude to two's complement
  // ****************************************
  assign magnitude = {33'h0, asym[14:0], 16'h0000};
  assign signed_value = asym[ASYM_SIGN] ? (64'h0 - magnitude) : magnitude;

  // ****************************************
  // Direction per message type
  // ****************************************
  assign do_add = ingress && (msg_type == MSG_SYNC || msg_type == MSG_PDELAY_RESP);
  assign do_sub = !ingress && (msg_type == MSG_DELAY_REQ || msg_type == MSG_PDELAY_REQ);

  always_comb begin
    corr_out = corr_in;
    if (do_add) begin
      corr_out = corr_in + signed_value;
    end else if (do_sub) begin
      corr_out = corr_in - signed_value;
    end
  end

  assign adjusted = do_add || do_sub;

endmodule

// >>> tb/port_lookup_ptp_config_tb_top.sv
// Self-checking bench for the per-port lookup, spanning-tree and PTP configuration bank.
// Assumes a single AHB-Lite slave, so HREADY is looped back from HREADYOUT.
module port_lookup_ptp_config_tb_top
  import port_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [15:0] haddr = 16'h0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout, hresp, decision_valid, frame_drop, mac_auth_en;
  logic [31:0] hrdata;
  wire logic hready;
  logic frame_valid = 1'b0;
  logic frame_tagged = 1'b0;
  logic [11:0] frame_vid = 12'h000;
  logic [11:0] default_vid = 12'h000;
  logic vlan_member = 1'b0;
  logic [47:0] source_mac = 48'h000000000000;
  logic [47:0] switch_mac = 48'h000000000000;
  logic global_self_filter = 1'b0;
  logic [11:0] lookup_vid;
  logic [7:0] tree_tx_en, tree_rx_en, tree_learn_dis;
  logic [15:0] rx_wire_delay_ns, tx_wire_delay_ns;
  logic ptp_valid = 1'b0;
  logic ptp_ingress = 1'b0;
  logic [3:0] ptp_msg_type = 4'h0;
  logic [63:0] ptp_corr_in = 64'h0;
  logic ptp_corr_valid, ptp_corr_out_adjusted;
  logic [63:0] ptp_corr_out;
  logic [64:0] rd_q[$], dec_q[$], ptp_q[$];
  logic rd_pend = 1'b0;
  logic [15:0] rnd = 16'ha585;
  logic [2:0] st[8];
  logic [7:0] ev_tx, ev_rx, ev_ld;
  logic [15:0] v, asym_v;
  int failures = 0;
  int checks_done = 0;

  assign hready = hreadyout;
  always #5 clk = ~clk;

  port_lookup_ptp_config i_dut (
    .CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hreadyout), .HRESP(hresp),
    .HRDATA(hrdata), .FRAME_VALID(frame_valid), .FRAME_TAGGED(frame_tagged),
    .FRAME_VID(frame_vid), .DEFAULT_VID(default_vid), .VLAN_MEMBER(vlan_member),
    .SOURCE_MAC(source_mac), .SWITCH_MAC(switch_mac), .GLOBAL_SELF_FILTER(global_self_filter),
    .DECISION_VALID(decision_valid), .FRAME_DROP(frame_drop), .LOOKUP_VID(lookup_vid),
    .MAC_AUTH_EN(mac_auth_en), .TREE_TX_EN(tree_tx_en), .TREE_RX_EN(tree_rx_en),
    .TREE_LEARN_DIS(tree_learn_dis), .RX_WIRE_DELAY_NS(rx_wire_delay_ns),
    .TX_WIRE_DELAY_NS(tx_wire_delay_ns), .PTP_VALID(ptp_valid), .PTP_INGRESS(ptp_ingress),
    .PTP_MSG_TYPE(ptp_msg_type), .PTP_CORR_IN(ptp_corr_in), .PTP_CORR_VALID(ptp_corr_valid),
    .PTP_CORR_OUT_ADJUSTED(ptp_corr_out_adjusted), .PTP_CORR_OUT(ptp_corr_out)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] rand16();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction

  task automatic chk(input logic [64:0] got, input logic [64:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Address phase held until HREADY, then data phase held until HREADY
  task automatic bus(input logic wr, input logic [15:0] addr, input logic [31:0] data);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= addr;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    if (wr) begin
      hwdata <= data;
    end
    do @(posedge clk); while (hready !== 1'b1);
  endtask

  task automatic wr(input logic [15:0] addr, input logic [31:0] data);
    bus(1'b1, addr, data);
  endtask

  task automatic rd(input logic [15:0] addr, input logic [31:0] exp);
    rd_q.push_back({33'h0, exp});
    bus(1'b0, addr, 32'h0);
  endtask

  // One frame per call, back to back; expectation from the lookup policy bits
  task automatic frame(input logic [7:0] c);
    logic [15:0] r, r2;
    logic [11:0] vid, lv;
    logic drop;
    r = rand16();
    r2 = rand16();
    vid = r[1] ? 12'h000 : (r[2] ? r2[11:0] : {r[15:12], r2[15:8]});
    lv = (!r[0] || (vid == 12'h000 && !c[7])) ? r2[11:0] : vid;
    drop = (c[6] && !r[3]) || (c[5] && lv != r2[11:0]) || (c[3] && r[5] && r[4]);
    dec_q.push_back({52'h0, drop, lv});
    @(posedge clk);
    frame_valid <= 1'b1;
    frame_tagged <= r[0];
    frame_vid <= vid;
    default_vid <= r2[11:0];
    vlan_member <= r[3];
    source_mac <= r[4] ? switch_mac : {switch_mac[47:1], ~switch_mac[0]};
    global_self_filter <= r[5];
  endtask

  task automatic ptp(input logic [15:0] a, input logic ing, input logic [3:0] ty);
    logic [63:0] corr, sgn, exp;
    logic add, sub;
    corr = {rand16(), rand16(), rand16(), rand16()};
    sgn = a[15] ? -{33'h0, a[14:0], 16'h0000} : {33'h0, a[14:0], 16'h0000};
    add = ing && (ty == MSG_SYNC || ty == MSG_PDELAY_RESP);
    sub = !ing && (ty == MSG_DELAY_REQ || ty == MSG_PDELAY_REQ);
    exp = add ? corr + sgn : (sub ? corr - sgn : corr);
    ptp_q.push_back({add || sub, exp});
    @(posedge clk);
    ptp_valid <= 1'b1;
    ptp_ingress <= ing;
    ptp_msg_type <= ty;
    ptp_corr_in <= corr;
  endtask

  // ****************************************
  // Monitor: oldest note against each result
  // ****************************************
  always @(posedge clk) begin
    if (rd_pend && rd_q.size() > 0) begin
      chk({33'h0, hrdata}, rd_q.pop_front());
    end
    rd_pend <= (hsel && htrans[1] && !hwrite && hready) === 1'b1;
    if (decision_valid === 1'b1 && dec_q.size() > 0) begin
      chk({52'h0, frame_drop, lookup_vid}, dec_q.pop_front());
    end
    if (ptp_corr_valid === 1'b1 && ptp_q.size() > 0) begin
      chk({ptp_corr_out_adjusted, ptp_corr_out}, ptp_q.pop_front());
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk(tree_tx_en, 8'hff);
    chk(tree_rx_en, 8'hff);
    chk(tree_learn_dis, 8'h00);
    chk(mac_auth_en, 1'b0);
    chk(hresp, 1'b0);
    chk(hreadyout, 1'b1);
    rd(ADDR_LOOKUP_CTRL, 32'h0);
    rd(ADDR_TREE_PTR, 32'h0);
    rd(ADDR_TREE_STATE, 32'h6);
    rd(ADDR_RX_DELAY, 32'h19f);
    rd(ADDR_TX_DELAY, 32'h2d);
    rd(ADDR_ASYM, 32'h0);
    rd(16'h2c08, 32'h0);
    wr(ADDR_LOOKUP_CTRL, 32'hffffffff);
    rd(ADDR_LOOKUP_CTRL, 32'hfa);
    @(negedge clk);
    chk(mac_auth_en, 1'b1);
    wr(ADDR_TREE_PTR, 32'hff);
    rd(ADDR_TREE_PTR, 32'hff);
    // Every entry written first, so a pointer that is ignored shows on readback
    for (int i = 0; i < 8; i++) begin
      v = rand16();
      st[i] = v[2:0];
      wr(ADDR_TREE_PTR, i);
      wr(ADDR_TREE_STATE, {24'h0, 5'h1f, st[i]});
    end
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_TREE_PTR, i);
      rd(ADDR_TREE_STATE, {29'h0, st[i]});
      ev_tx[i] = st[i][2];
      ev_rx[i] = st[i][1];
      ev_ld[i] = st[i][0];
    end
    @(negedge clk);
    chk(tree_tx_en, ev_tx);
    chk(tree_rx_en, ev_rx);
    chk(tree_learn_dis, ev_ld);
    v = rand16();
    wr(ADDR_RX_DELAY, {16'hffff, v});
    rd(ADDR_RX_DELAY, {16'h0, v});
    @(negedge clk);
    chk(rx_wire_delay_ns, v);
    v = rand16();
    wr(ADDR_TX_DELAY, {16'hffff, v});
    rd(ADDR_TX_DELAY, {16'h0, v});
    @(negedge clk);
    chk(tx_wire_delay_ns, v);
    @(posedge clk);
    switch_mac <= {rand16(), rand16(), rand16()};
    for (int c = 0; c < 16; c++) begin
      v = {8'h00, c[3], c[2], c[1], 1'b0, c[0], 3'b000};
      wr(ADDR_LOOKUP_CTRL, {24'h0, v[7:0]});
      repeat (8) frame(v[7:0]);
      @(posedge clk);
      frame_valid <= 1'b0;
    end
    // Magnitude kept non-zero so that an applied correction is visible
    for (int a = 0; a < 3; a++) begin
      v = rand16();
      asym_v = (a == 2) ? 16'hffff : {a[0], v[14:1], 1'b1};
      wr(ADDR_ASYM, {16'h0, asym_v});
      rd(ADDR_ASYM, {16'h0, asym_v});
      for (int k = 0; k < 10; k++) begin
        ptp(asym_v, k[0], k[4:1]);
      end
      @(posedge clk);
      ptp_valid <= 1'b0;
    end
    repeat (4) @(posedge clk);
    chk(65'(rd_q.size() + dec_q.size() + ptp_q.size()), 65'h0);
    end_of_test();
  end

  // Whole sequence takes a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end

endmodule
